// file: rtl/qpm_mii_consts.svh
// constants of the quad-port mii data path
// assumes a 10 mhz system clock; included by the package and the port module
`ifndef QPM_MII_CONSTS_SVH
`define QPM_MII_CONSTS_SVH

`define QPM_NUM_PORTS 4
`define QPM_NIB_W 4
`define QPM_SYM_W 5
`define QPM_FIFO_DEPTH 4
`define QPM_SYS_CLK_NS 100
`define QPM_TXCLK100_PERIOD_NS 40
`define QPM_TXCLK10_PERIOD_NS 400
`define QPM_SYM_IDLE 5'h1F
`define QPM_SYM_HALT 5'h04
`define QPM_NIB_ZERO 4'h0

`endif

// file: rtl/qpm_mii_pkg.sv
// types and line-code functions shared by the mii data path
// assumes the constants header is on the include path
package qpm_mii_pkg;
`include "qpm_mii_consts.svh"

  typedef logic [`QPM_NIB_W-1:0] qpm_nib_type;
  typedef logic [`QPM_SYM_W-1:0] qpm_sym_type;
  // received word: valid-data flag above the nibble
  typedef logic [`QPM_NIB_W:0] qpm_rx_word_type;

  function automatic qpm_sym_type qpm_encode(input qpm_nib_type nib);
    qpm_sym_type s;
    case (nib)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      default: s = 5'h1D;
    endcase
    return s;
  endfunction

  // reverse lookup through the encoder, so both tables can never disagree
  function automatic qpm_rx_word_type qpm_decode(input qpm_sym_type sym);
    qpm_rx_word_type w;
    w = '0;
    for (int i = 0; i < (1 << `QPM_NIB_W); i++) begin
      if (qpm_encode(qpm_nib_type'(i)) == sym) begin
        w = {1'b1, qpm_nib_type'(i)};
      end
    end
    return w;
  endfunction
endpackage

// file: rtl/qpm_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes a single clock; ready and valid come from flops
`timescale 1ns/1ps
module qpm_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("qpm_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } qpm_fifo_state_type;

  qpm_fifo_state_type st_r;
  qpm_fifo_state_type st_nxt;

  always_comb begin
    logic push;
    logic pop;
    logic [AW:0] c;
    push = in_valid && st_r.rdy;
    pop = out_ready && st_r.vld;
    st_nxt = st_r;
    c = st_r.cnt;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
      c = c + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
      c = c - 1'b1;
    end
    st_nxt.cnt = c;
    // flags registered with the count, so they are honest the cycle after
    st_nxt.rdy = (c != (AW+1)'(DEPTH));
    st_nxt.vld = (c != '0);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready = st_r.rdy;
  assign out_valid = st_r.vld;
  assign out_data = st_r.mem[st_r.rp];
endmodule

// file: rtl/qpm_mii_port.sv
// quad mii data path: tx clock generation, tx capture and coding, rx nibble output
// assumes line-side symbols come from logic on sys_clk; mac pins are asynchronous
//
// How it works
// - each port drives tx clock, fast rate at 100 mbps, slow at 10 mbps
// - by default tx inputs are captured on the tx clock rising edge
// - advanced mode input set: capture moves to the tx clock falling edge
// - transmitter sends data only while tx enable is high
// - tx error high sends the halt code group instead of data
// - received data leaves as 4-bit nibbles changing with the port rx clock
// - four independent sets of tx and rx signals, ports 0 to 3
// - management bits named register.bit; registers 0-6, 16-20, bits 0-15
// - rx valid is high with rx clock whenever the symbol decodes to data
`timescale 1ns/1ps
`include "qpm_mii_consts.svh"
module qpm_mii_port
  import qpm_mii_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int FIFO_DEPTH = `QPM_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`QPM_NUM_PORTS-1:0] speed_100,
  input wire logic [`QPM_NUM_PORTS-1:0] adv_txclk_mode,
  input wire logic [`QPM_NUM_PORTS-1:0] tx_en,
  input wire logic [`QPM_NUM_PORTS-1:0] tx_er,
  input wire logic [`QPM_NUM_PORTS-1:0][`QPM_NIB_W-1:0] txd,
  output logic [`QPM_NUM_PORTS-1:0] tx_clk,
  output logic [`QPM_NUM_PORTS-1:0] rx_clk,
  output logic [`QPM_NUM_PORTS-1:0][`QPM_NIB_W-1:0] rxd,
  output logic [`QPM_NUM_PORTS-1:0] rx_dv,
  output logic [`QPM_NUM_PORTS-1:0][`QPM_SYM_W-1:0] line_tx_sym,
  output logic [`QPM_NUM_PORTS-1:0] line_tx_stb,
  input wire logic [`QPM_NUM_PORTS-1:0][`QPM_SYM_W-1:0] line_rx_sym,
  input wire logic [`QPM_NUM_PORTS-1:0] line_rx_stb,
  output logic [`QPM_NUM_PORTS-1:0] line_rx_rdy
);
  import qpm_mii_pkg::*;

  localparam int NP = `QPM_NUM_PORTS;
  // each half period rounds down, never below one cycle
  localparam int HALF100_RAW = (`QPM_TXCLK100_PERIOD_NS / 2) / `QPM_SYS_CLK_NS;
  localparam int HALF10_RAW = (`QPM_TXCLK10_PERIOD_NS / 2) / `QPM_SYS_CLK_NS;
  localparam int HALF100 = (HALF100_RAW < 1) ? 1 : HALF100_RAW;
  localparam int HALF10 = (HALF10_RAW < 1) ? 1 : HALF10_RAW;

  generate
    if ((1 << DIV_W) <= HALF10 || DIV_W > 16) begin : g_bad_div
      $error("qpm_mii_port: DIV_W cannot hold the slow half period");
    end
  endgenerate

  typedef struct packed {
    logic [NP-1:0] en_s1;
    logic [NP-1:0] en_s2;
    logic [NP-1:0] er_s1;
    logic [NP-1:0] er_s2;
    logic [NP-1:0][`QPM_NIB_W-1:0] txd_s1;
    logic [NP-1:0][`QPM_NIB_W-1:0] txd_s2;
    logic [NP-1:0][DIV_W-1:0] cnt;
    logic [NP-1:0] clk;
    logic [NP-1:0][`QPM_SYM_W-1:0] sym;
    logic [NP-1:0] stb;
    logic [NP-1:0] dv;
    logic [NP-1:0][`QPM_NIB_W-1:0] rxd;
  } qpm_mii_state_type;

  qpm_mii_state_type st_r;
  qpm_mii_state_type st_nxt;

  logic [NP-1:0] pop_w;
  logic [NP-1:0] fifo_vld;
  logic [NP-1:0][`QPM_NIB_W:0] fifo_data;

  // one receive buffer per port keeps the ports independent
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      qpm_fifo #(
        .WIDTH(`QPM_NIB_W + 1),
        .DEPTH(FIFO_DEPTH)
      ) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(line_rx_stb[gp]),
        .in_ready(line_rx_rdy[gp]),
        .in_data(qpm_decode(line_rx_sym[gp])),
        .out_valid(fifo_vld[gp]),
        .out_ready(pop_w[gp]),
        .out_data(fifo_data[gp])
      );
    end
  endgenerate

  always_comb begin
    logic [DIV_W-1:0] half;
    logic tick;
    logic rise;
    logic fall;
    logic cap;
    half = '0;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cap = 1'b0;
    st_nxt = st_r;
    pop_w = '0;
    // two flops on every mac pin; the first stage feeds only the second
    st_nxt.en_s1 = tx_en;
    st_nxt.en_s2 = st_r.en_s1;
    st_nxt.er_s1 = tx_er;
    st_nxt.er_s2 = st_r.er_s1;
    st_nxt.txd_s1 = txd;
    st_nxt.txd_s2 = st_r.txd_s1;
    st_nxt.stb = '0;
    for (int p = 0; p < NP; p++) begin
      // sys_clk cannot reach 25 mhz, so the fast rate is the fastest divider
      half = speed_100[p] ? DIV_W'(HALF100) : DIV_W'(HALF10);
      tick = (st_r.cnt[p] >= half - 1'b1);
      rise = tick && !st_r.clk[p];
      fall = tick && st_r.clk[p];
      if (tick) begin
        st_nxt.cnt[p] = '0;
        st_nxt.clk[p] = !st_r.clk[p];
      end else begin
        st_nxt.cnt[p] = st_r.cnt[p] + 1'b1;
      end
      // mode input stands in for management bit 19.5; no register file lives here
      // capture edge chosen per port, relies on
      cap = adv_txclk_mode[p] ? fall : rise;
      if (cap) begin
        st_nxt.stb[p] = 1'b1;
        if (st_r.er_s2[p]) begin
          st_nxt.sym[p] = `QPM_SYM_HALT;
        end else if (st_r.en_s2[p]) begin
          st_nxt.sym[p] = qpm_encode(st_r.txd_s2[p]);
        end else begin
          st_nxt.sym[p] = `QPM_SYM_IDLE;
        end
      end
      // rx outputs change on the falling edge so the mac samples them stable on rising
      if (fall) begin
        pop_w[p] = 1'b1;
        st_nxt.dv[p] = fifo_vld[p] && fifo_data[p][`QPM_NIB_W];
        st_nxt.rxd[p] = fifo_vld[p] ? fifo_data[p][`QPM_NIB_W-1:0] : `QPM_NIB_ZERO;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // rx clock shares the tx divider; both come straight from the clk flop
  assign tx_clk = st_r.clk;
  assign rx_clk = st_r.clk;
  assign rxd = st_r.rxd;
  assign rx_dv = st_r.dv;
  assign line_tx_sym = st_r.sym;
  assign line_tx_stb = st_r.stb;
endmodule

// file: tb/qpm_mac_model.sv
// mac side: loads wanted pin values at each tx clock rise
// assumes tx_clk is seen by sys_clk sampling
`timescale 1ns/1ps
module qpm_mac_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] tx_clk,
  input wire logic [3:0] want_en,
  input wire logic [3:0] want_er,
  input wire logic [3:0][3:0] want_d,
  output logic [3:0] tx_en,
  output logic [3:0] tx_er,
  output logic [3:0][3:0] txd
);
  logic [3:0] clk_q;
  always @(posedge sys_clk or posedge rst) begin
    clk_q <= tx_clk;
    for (int p = 0; p < 4; p++) begin
      if (rst) {tx_en[p], tx_er[p], txd[p]} <= '0;
      else if (tx_clk[p] && !clk_q[p]) {tx_en[p], tx_er[p], txd[p]} <= {want_en[p], want_er[p], want_d[p]};
    end
  end
endmodule

// file: tb/qpm_mii_port_sva.sv
// checker on port 0 of the mii data path
// assumes speed and mode change only in reset
`timescale 1ns/1ps
module qpm_mii_port_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] speed_100,
  input wire logic [3:0] adv_txclk_mode,
  input wire logic [3:0] tx_en,
  input wire logic [3:0] tx_er,
  input wire logic [3:0] tx_clk,
  input wire logic [3:0] rx_clk,
  input wire logic [3:0][3:0] rxd,
  input wire logic [3:0] rx_dv,
  input wire logic [3:0][4:0] line_tx_sym,
  input wire logic [3:0] line_tx_stb
);
  logic [3:0] en_h, er_h;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bits 3..1 cover every age the synchroniser may capture
  always_ff @(posedge sys_clk) begin
    en_h <= {en_h[2:0], tx_en[0]};
    er_h <= {er_h[2:0], tx_er[0]};
  end
  fast_clk_a: assert property (speed_100[0] && $rose(tx_clk[0]) |=> !tx_clk[0]) else $error("fast");
  slow_clk_a: assert property (!speed_100[0] && $rose(tx_clk[0]) |=> tx_clk[0] ##1 !tx_clk[0])
    else $error("slow");
  rise_cap_a: assert property (!adv_txclk_mode[0] |-> line_tx_stb[0] == $rose(tx_clk[0])) else $error("rise");
  fall_cap_a: assert property (adv_txclk_mode[0] |-> line_tx_stb[0] == $fell(tx_clk[0])) else $error("fall");
  halt_sym_a: assert property (line_tx_stb[0] && &er_h[3:1] |-> line_tx_sym[0] == 5'h04) else $error("halt");
  idle_sym_a: assert property (line_tx_stb[0] && !(|en_h[3:1] || |er_h[3:1]) |-> line_tx_sym[0] == 5'h1F)
    else $error("idle");
  data_sym_a: assert property (line_tx_stb[0] && &en_h[3:1] && !(|er_h[3:1])
    |-> !(line_tx_sym[0] inside {5'h04, 5'h1F})) else $error("data");
  dv_edge_a: assert property ($changed(rx_dv[0]) || $changed(rxd[0]) |-> $fell(rx_clk[0])) else $error("rx");
endmodule
bind qpm_mii_port qpm_mii_port_sva u_sva (.sys_clk, .rst, .speed_100, .adv_txclk_mode, .tx_en, .tx_er, .tx_clk,
  .rx_clk, .rxd, .rx_dv, .line_tx_sym, .line_tx_stb);

// file: tb/qpm_mii_port_test.sv
// bench for the quad mii data path
// assumes model and checker compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module qpm_mii_port_test;
  logic sys_clk = 0, rst = 1;
  logic [3:0] speed_100 = 0, adv_txclk_mode = 0, w_en = 0, w_er = 0, line_rx_stb = 0;
  logic [3:0][3:0] w_d = 0;
  logic [3:0][4:0] line_rx_sym = 0;
  wire logic [3:0] tx_en, tx_er, tx_clk, rx_clk, rx_dv, line_tx_stb, line_rx_rdy;
  wire logic [3:0][3:0] txd, rxd;
  wire logic [3:0][4:0] line_tx_sym;
  int errors = 0, n_tests = 0;
  logic [31:0] st = 74785;
  logic [4:0] q[$], nib;
  logic prev_rc;
  logic [4:0] tbl [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  function automatic logic [4:0] exp_sym(input logic en, input logic er, input logic [3:0] d);
    return er ? 5'h04 : (en ? tbl[d] : 5'h1F);
  endfunction
  task automatic wrap_up();
    $display("checks %0d bad %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  qpm_mii_port dut (.sys_clk, .rst, .speed_100, .adv_txclk_mode, .tx_en, .tx_er, .txd, .tx_clk, .rx_clk, .rxd,
    .rx_dv, .line_tx_sym, .line_tx_stb, .line_rx_sym, .line_rx_stb, .line_rx_rdy);
  qpm_mac_model mac (.sys_clk, .rst, .tx_clk, .want_en(w_en), .want_er(w_er), .want_d(w_d), .tx_en, .tx_er, .txd);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // nibbles leave only where rx clock falls
  always @(posedge sys_clk) begin
    prev_rc <= rx_clk[0];
    if (!rst && prev_rc && !rx_clk[0] && rx_dv[0]) begin
      nib = q.size() > 0 ? q.pop_front() : 5'h10;
      `CHK({1'b0, rxd[0]}, nib)
    end
  end
  initial begin
    // about 150 cycles per phase; far more than four phases need
    #2000000;
    errors++;
    wrap_up();
  end
  initial begin
    logic [31:0] r;
    logic [4:0] s;
    for (int ph = 0; ph < 4; ph++) begin
      r = xs();
      rst <= 1;
      speed_100 <= {r[3:1], ph[0]};
      adv_txclk_mode <= {r[6:4], ph[1]};
      q.delete();
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      for (int k = 0; k < 6; k++) begin
        r = xs();
        w_en <= k == 0 ? 4'h0 : r[3:0];
        w_er <= k == 1 ? 4'hF : r[7:4] & r[11:8];
        w_d <= r[31:16];
        repeat (16) @(posedge sys_clk);
        for (int p = 0; p < 4; p++) `CHK(line_tx_sym[p], exp_sym(w_en[p], w_er[p], w_d[p]))
      end
      // back to back pushes overrun the fifo at the slow rate
      for (int i = 0; i < 7; i++) begin
        r = xs();
        s = i == 3 ? 5'h1F : tbl[r[3:0]];
        line_rx_stb <= 4'hF;
        line_rx_sym <= {4{s}};
        @(posedge sys_clk);
        if (line_rx_rdy[0] && s != 5'h1F) q.push_back({1'b0, r[3:0]});
      end
      line_rx_stb <= 0;
      repeat (40) @(posedge sys_clk);
      `CHK(q.size(), 0)
      `CHK(rx_dv, 4'h0)
      `CHK(line_rx_rdy, 4'hF)
      $display("phase %0d done", ph);
    end
    wrap_up();
  end
endmodule
